/* File: design/cmc_pkg.sv */
// Constants for the four-port core memory controller.
// Assumes a single 25 MHz system clock and one active-low asynchronous reset.
// Function
// - Each stored word is 18 bits: 16 data, parity, protection.
// - Read is destructive readout half-cycle then rewrite of the same word.
// - Write is clear half-cycle then write half-cycle storing new value.
// - Each half-cycle lasts 400 ns; full cycle is 800 ns.
// - Transfers always move whole words; byte selection belongs to requesters.
// - Addresses are byte addresses; even addresses name word locations.
// - Storage is 4096-word modules, up to 32768 words total.
// - Four independent request ports serve processors or DMA controllers.
// - Control logic generates all half-cycle timing for the array.
// - Control logic generates transfer handshakes moving words to requesters.
// - Simultaneous requests are resolved by port priority.
// - Protected words are reachable only when protection_key equals 1.
package cmc_pkg;
    localparam int CMC_DATA_W = 16;
    localparam int CMC_WORD_W = 18;
    localparam int CMC_PAR_BIT = 16;
    localparam int CMC_PROT_BIT = 17;
    localparam int CMC_ADDR_W = 15;
    localparam int CMC_MOD_WORDS = 4096;
    localparam int CMC_MAX_MODULES = 8;
    localparam int CMC_PORTS = 4;
    localparam int CMC_CLK_NS = 40;
    localparam int CMC_HALF_NS = 400;
    localparam int CMC_HALF_CYC = (CMC_HALF_NS + CMC_CLK_NS - 1) / CMC_CLK_NS;
    localparam logic [3:0] CMC_HALF_LAST = 4'(CMC_HALF_CYC - 1);
    localparam logic [17:0] CMC_WORD_RST = 18'h00000;

    typedef enum logic [2:0] {
        CMC_IDLE    = 3'b000,
        CMC_READOUT = 3'b001,
        CMC_REWRITE = 3'b010,
        CMC_CLEAR   = 3'b011,
        CMC_WRITE   = 3'b100
    } cmc_state_t;
endpackage

/* File: design/cmc_array.sv */
// Ferrite-core storage array model: a word memory with registered read data.
// Assumes the controller sequences it; a read destroys the word and a clear empties it.
`timescale 1ns/10ps
module cmc_array
    import cmc_pkg::*;
#(
    parameter int WORDS = CMC_MOD_WORDS * CMC_MAX_MODULES,
    parameter int AW = CMC_ADDR_W
) (
    // Clock.
    input wire logic sys_clk,
    // Strobes.
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic clr_en,
    // Address and data.
    input wire logic [AW-1:0] addr,
    input wire logic [CMC_WORD_W-1:0] wdata,
    output logic [CMC_WORD_W-1:0] rdata
);
    logic [CMC_WORD_W-1:0] mem [WORDS];

    // Core readout is destructive, so the sensed word is zeroed in place.
    always_ff @(posedge sys_clk) begin
        if (rd_en || clr_en) begin
            mem[addr] <= CMC_WORD_RST;
        end else if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rdata <= mem[addr];
        end
    end
endmodule

/* File: design/cmc_ctrl.sv */
// Four-port core memory controller: arbitration, half-cycle timing, transfers.
// Assumes requesters on sys_clk hold req, addr, write data until their ack pulse.
`timescale 1ns/10ps
module cmc_ctrl
    import cmc_pkg::*;
#(
    parameter int NPORT = CMC_PORTS,
    parameter int MODULES = CMC_MAX_MODULES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Requests, one bit or slice per port.
    input wire logic [NPORT-1:0] req,
    input wire logic [NPORT-1:0] we,
    input wire logic [NPORT-1:0] protection_key,
    input wire logic [NPORT*16-1:0] byte_addr,
    input wire logic [NPORT*CMC_WORD_W-1:0] wdata,
    // Answers.
    output logic [NPORT-1:0] ack,
    output logic [NPORT-1:0] prot_err,
    output logic [CMC_WORD_W-1:0] rdata,
    output logic busy
);
    localparam int WORDS = CMC_MOD_WORDS * MODULES;

    cmc_state_t state_r;
    logic [3:0] tick_r;
    logic [1:0] port_r;
    logic [CMC_ADDR_W-1:0] addr_r;
    logic [CMC_WORD_W-1:0] wword_r;
    logic [CMC_WORD_W-1:0] sensed;
    logic [CMC_WORD_W-1:0] rdata_r;
    logic [NPORT-1:0] ack_r;
    logic [NPORT-1:0] perr_r;
    logic key_r;
    logic any_req;
    logic [1:0] win;
    logic half_end;

    // Lowest numbered requester wins.
    always_comb begin
        any_req = |req;
        win = 2'd0;
        for (int i = NPORT - 1; i >= 0; i--) begin
            if (req[i]) begin
                win = 2'(i);
            end
        end
    end

    assign half_end = (tick_r == CMC_HALF_LAST);

    // Half-cycle sequencer; a grant is only taken from idle, so a cycle always completes.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= CMC_IDLE;
            tick_r <= 4'h0;
        end else begin
            case (state_r)
                CMC_IDLE: begin
                    tick_r <= 4'h0;
                    if (any_req && ack_r == '0) begin
                        state_r <= we[win] ? CMC_CLEAR : CMC_READOUT;
                    end
                end
                CMC_READOUT: begin
                    tick_r <= half_end ? 4'h0 : tick_r + 4'h1;
                    if (half_end) begin
                        state_r <= CMC_REWRITE;
                    end
                end
                CMC_CLEAR: begin
                    tick_r <= half_end ? 4'h0 : tick_r + 4'h1;
                    if (half_end) begin
                        state_r <= CMC_WRITE;
                    end
                end
                CMC_REWRITE, CMC_WRITE: begin
                    tick_r <= half_end ? 4'h0 : tick_r + 4'h1;
                    if (half_end) begin
                        state_r <= CMC_IDLE;
                    end
                end
                default: begin
                    state_r <= CMC_IDLE;
                    tick_r <= 4'h0;
                end
            endcase
        end
    end

    // Latch the winning request; the byte bit is dropped to form a word index.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            port_r <= 2'd0;
            addr_r <= '0;
            wword_r <= CMC_WORD_RST;
            key_r <= 1'b0;
        end else if (state_r == CMC_IDLE && any_req && ack_r == '0) begin
            port_r <= win;
            addr_r <= byte_addr[win*16+1 +: CMC_ADDR_W];
            wword_r <= wdata[win*CMC_WORD_W +: CMC_WORD_W];
            key_r <= protection_key[win];
        end
    end

    // Rewrite restores what was sensed; a refused write keeps the old word too.
    logic keep_old_r;
    logic [CMC_WORD_W-1:0] old_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            old_r <= CMC_WORD_RST;
            keep_old_r <= 1'b0;
        end else if ((state_r == CMC_READOUT || state_r == CMC_CLEAR) && tick_r == 4'h1) begin
            old_r <= sensed;
            keep_old_r <= sensed[CMC_PROT_BIT] && !key_r;
        end
    end

    logic arr_rd;
    logic arr_wr;
    logic [CMC_WORD_W-1:0] arr_wdata;
    // A clear half-cycle senses too, so protection is known before anything is lost.
    assign arr_rd = (state_r == CMC_READOUT || state_r == CMC_CLEAR) && tick_r == 4'h0;
    assign arr_wr = (state_r == CMC_REWRITE || state_r == CMC_WRITE) && tick_r == 4'h0;
    assign arr_wdata = (state_r == CMC_WRITE && !keep_old_r) ? wword_r : old_r;

    // The clear strobe empties the word while the same half-cycle senses its protection bit.
    logic arr_clr;
    assign arr_clr = (state_r == CMC_CLEAR) && tick_r == 4'h0;

    cmc_array #(
        .WORDS(WORDS),
        .AW(CMC_ADDR_W)
    ) u_array (
        .sys_clk(sys_clk),
        .rd_en(arr_rd),
        .wr_en(arr_wr),
        .clr_en(arr_clr),
        .addr(addr_r),
        .wdata(arr_wdata),
        .rdata(sensed)
    );

    // Answer at the end of the restore half-cycle; data and flag stand until next answer.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= '0;
            perr_r <= '0;
            rdata_r <= CMC_WORD_RST;
        end else begin
            ack_r <= '0;
            if ((state_r == CMC_REWRITE || state_r == CMC_WRITE) && half_end) begin
                ack_r[port_r] <= 1'b1;
                perr_r <= '0;
                perr_r[port_r] <= keep_old_r;
                rdata_r <= (state_r == CMC_REWRITE && !keep_old_r) ? old_r : CMC_WORD_RST;
            end
        end
    end

    assign ack = ack_r;
    assign prot_err = perr_r;
    assign rdata = rdata_r;
    assign busy = (state_r != CMC_IDLE);

    // Assertions.
    // A half-cycle is built from two runs of five clocks to keep each repetition short.
    sequence s_access_five;
        (state_r == CMC_READOUT || state_r == CMC_CLEAR) [*5];
    endsequence

    sequence s_access_half;
        s_access_five ##1 s_access_five;
    endsequence

    sequence s_restore_five;
        (state_r == CMC_REWRITE || state_r == CMC_WRITE) [*5];
    endsequence

    sequence s_restore_half;
        s_restore_five ##1 s_restore_five;
    endsequence

    a_half_len: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(busy) |-> s_access_half)
        else $error("access half-cycle not 400 ns");
    a_read_rewrite: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == CMC_READOUT && half_end) |=> state_r == CMC_REWRITE)
        else $error("readout not followed by rewrite");
    a_clear_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == CMC_CLEAR && half_end) |=> state_r == CMC_WRITE)
        else $error("clear not followed by write");
    a_full_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(busy) |-> ##19 (busy && half_end) ##1 (ack != '0))
        else $error("full cycle not 800 ns");
    a_ack_onehot: assert property (@(posedge sys_clk) disable iff (!nrst)
        $onehot0(ack))
        else $error("more than one port answered");
    a_prio_grant: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!busy && req[0] && ack == '0) |=> (busy && port_r == 2'd0))
        else $error("port zero not granted first");
    a_no_preempt: assert property (@(posedge sys_clk) disable iff (!nrst)
        (busy && !$rose(busy)) |-> $stable(port_r) && $stable(addr_r))
        else $error("grant changed mid-cycle");
    a_prot_refuse: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ack != '0 && prot_err != '0) |-> rdata == CMC_WORD_RST)
        else $error("protected word delivered");
    a_addr_word: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(busy) |-> addr_r == $past(byte_addr[win*16+1 +: CMC_ADDR_W]))
        else $error("word address not byte address shifted");

    a_restore_half: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(busy) |-> ##10 s_restore_half)
        else $error("restore half-cycle not 400 ns");

    a_ack_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ack != '0) |-> !busy ##1 !busy)
        else $error("grant taken in the answer cycle");

    a_end_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(busy) |-> ack != '0)
        else $error("cycle ended without an answer");

    a_data_stands: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ack == '0) |-> $stable(rdata) && $stable(prot_err))
        else $error("read data changed between answers");
endmodule

/* File: bench/cmc_requester.sv */
// Model of the four requesters that face the memory controller.
// Assumes issue is called just after an edge and never for a port still waiting.
`timescale 1ns/10ps
module cmc_requester
    import cmc_pkg::*;
(
    // Clock and answers.
    input wire logic sys_clk,
    input wire logic [3:0] ack,
    // Requests.
    output logic [3:0] req,
    output logic [3:0] we,
    output logic [3:0] protection_key,
    output logic [63:0] byte_addr,
    output logic [71:0] wdata
);
    logic [3:0] seen;
    initial begin
        req = 4'h0;
        we = 4'h0;
        protection_key = 4'h0;
        byte_addr = 64'h0;
        wdata = 72'h0;
    end
    task automatic issue(input int p, input logic w, input logic k, input logic [15:0] a, input logic [17:0] d);
        we[p] = w;
        protection_key[p] = k;
        byte_addr[16*p+:16] = a;
        wdata[18*p+:18] = d;
        req[p] = 1'b1;
    endtask
    // req is dropped and the other released lines are inverted so that a stale value can never pass for a held one.
    always @(posedge sys_clk) begin
        seen = ack;
        #1;
        for (int i = 0; i < 4; i++) begin
            if (seen[i]) begin
                req[i] = 1'b0;
                we[i] = ~we[i];
                protection_key[i] = ~protection_key[i];
                byte_addr[16*i+:16] = ~byte_addr[16*i+:16];
                wdata[18*i+:18] = ~wdata[18*i+:18];
            end
        end
    end
endmodule

/* File: bench/core_memory_port_controller_bench.sv */
// Self-checking bench for the four-port core memory controller.
// Assumes the requester model drops each request one clock after its answer.
`timescale 1ns/10ps
module core_memory_port_controller_bench
    import cmc_pkg::*;
;
    typedef struct {int p; logic [17:0] d; logic e;} cmc_note_t;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] req, we, protection_key, ack, prot_err;
    logic [63:0] byte_addr;
    logic [71:0] wdata;
    logic [17:0] rdata;
    logic busy;
    logic [17:0] mem [int];
    logic [15:0] a [4] = '{16'h0000, 16'h1ffe, 16'h2000, 16'hfffe};
    cmc_note_t notes[$];
    int n_errors = 0;
    int checks_done = 0;
    always #20 sys_clk = ~sys_clk;
    cmc_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .req(req), .we(we), .protection_key(protection_key),
        .byte_addr(byte_addr), .wdata(wdata), .ack(ack), .prot_err(prot_err), .rdata(rdata), .busy(busy));
    cmc_requester partner_u (.sys_clk(sys_clk), .ack(ack), .req(req), .we(we),
        .protection_key(protection_key), .byte_addr(byte_addr), .wdata(wdata));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The note is made at issue time, so expectations never lean on the outputs.
    task automatic op(input int p, input logic w, input logic k, input logic [15:0] ad, input logic [17:0] d);
        int i;
        logic e;
        i = int'(ad[15:1]);
        e = mem.exists(i) && mem[i][17] && !k;
        if (w && !e) begin
            mem[i] = d;
        end
        notes.push_back('{p, (w || e) ? 18'h0 : mem[i], e});
        partner_u.issue(p, w, k, ad, d);
    endtask
    task automatic settle();
        int n;
        n = 0;
        while ((req !== 4'h0 || busy !== 1'b0 || notes.size() != 0) && n < 500) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("idle wait", n >= 500, 0);
        if (n >= 500) begin
            finish_test();
        end
        @(posedge sys_clk);
        #1;
    endtask
    task automatic timed(input int p, input logic w, input logic k, input logic [15:0] ad, input logic [17:0] d);
        int n;
        int b;
        n = 0;
        b = 0;
        op(p, w, k, ad, d);
        do begin
            @(posedge sys_clk);
            n++;
            b += int'(busy === 1'b1);
        end while (ack[p] !== 1'b1 && n < 100);
        check("ack latency", n, 22);
        check("busy cycles", b, 20);
        if (n >= 100) begin
            finish_test();
        end
        settle();
    endtask
    always @(posedge sys_clk) begin
        cmc_note_t n;
        if (ack !== 4'h0) begin
            if (notes.size() == 0) begin
                check("stray ack", ack, 0);
            end else begin
                n = notes.pop_front();
                check("ack port", ack, 32'(1) << n.p);
                check("rdata", rdata, n.d);
                check("prot_err", prot_err, 32'(n.e) << n.p);
            end
        end
    end
    initial begin
        void'($urandom(32'hddc452eb));
        repeat (8) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        // Key 1 on first writes, as the stored protection bit is unknown until then.
        for (int p = 0; p < 4; p++) begin
            timed(p, 1'b1, 1'b1, a[p], 18'($urandom) & 18'h1ffff);
            timed(p, 1'b0, 1'b0, a[p] | 16'h1, 18'h0);
            timed(p, 1'b0, 1'b0, a[p], 18'h0);
        end
        $display("test ports done");
        op(0, 1'b1, 1'b1, 16'h0100, 18'h20000 | 18'($urandom));
        settle();
        for (int j = 0; j < 5; j++) begin
            op(j % 4, j == 0 || j == 3, j[1], 16'h0100, 18'($urandom));
            settle();
        end
        $display("test protection done");
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 4; p++) begin
                op(p, p[0] ^ r[0], 1'b1, a[p], 18'($urandom));
            end
            settle();
        end
        $display("test contention done");
        finish_test();
    end
endmodule
